// ---- shared/pcsr_pkg.sv ----
// package for the packet client register bank: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite slave with word-index offsets scaled by four
package pcsr_pkg;

    // printed offsets are word indices; byte address is four times the index
    localparam logic [15:0] IDX_SCRATCH = 16'h1000;
    localparam logic [15:0] IDX_IDENT = 16'h1001;
    localparam logic [15:0] IDX_FEATURE = 16'h1002;
    localparam logic [15:0] IDX_TEMP = 16'h1006;
    localparam logic [15:0] IDX_GENCTRL = 16'h1010;
    localparam logic [15:0] IDX_LBERR = 16'h1015;
    localparam logic [15:0] IDX_LBRESET = 16'h1016;
    localparam logic [15:0] IDX_IRQSTAT = 16'h1020;
    localparam logic [15:0] IDX_IRQMASK = 16'h1021;

    localparam int ADDR_W = 18;

    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
    // identification string value is arbitrary
    localparam logic [31:0] IDENT_VALUE = 32'h4241_4E4B;
    localparam logic [3:0] GENCTRL_RESET = 4'h5;
    localparam logic [1:0] LBERR_RESET = 2'h0;
    localparam logic LBRESET_RESET = 1'b0;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    localparam int FEAT_FAMILY = 0;
    localparam int FEAT_LL100 = 1;
    localparam int FEAT_REFCLK = 2;
    localparam int FEAT_FOURLANE = 4;
    localparam int FEAT_TSTAMP = 5;
    localparam int FEAT_LFAULT = 6;
    localparam int FEAT_EXTPLL = 8;
    localparam int FEAT_STDSTREAM = 9;
    localparam int FEAT_W = 10;

    localparam int GEN_DISABLE = 1;
    localparam int GEN_LOOPBACK = 3;
    localparam int LB_UNDER = 0;
    localparam int LB_OVER = 1;
    localparam int LB_CLEAR = 2;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- core/pcsr_bank.sv ----
// packet client control and status register bank behind an AXI4-Lite slave
// assumes one clock core_clk, async active-low resetn, event pulses on core_clk
//
// Summary of operation
// RULE1 - a 32-bit read-write scratch word has no effect beyond reading back what was written.
// RULE2 - a read-only word returns a fixed four-character identification string, one per byte.
// RULE3 - feature bit 0 tells which of two device families the attached core targets.
// RULE4 - feature bit 1 reads 1 when the attached core is the low-latency 100G MAC.
// RULE5 - feature bit 2 reads 0 for a 322 MHz reference clock and 1 for 644 MHz.
// RULE6 - feature bits 4 to 6 flag core properties: four-lane, timestamp and local fault.
// RULE7 - feature bit 8, external transmit PLL, always reads 0.
// RULE8 - feature bit 9, standard streaming client interface, always reads 1.
// RULE9 - an 8-bit read-only word shows the die temperature reading in Fahrenheit.
// RULE10 - generator control bit 1 stops the generator when 1; the field resets to 0101.
// RULE11 - generator control bit 3 reads 1 in loopback mode and 0 with the generator.
// RULE12 - an underflow of the loopback fifo sets error bit 0, which stays until cleared.
// RULE13 - an overflow of the loopback fifo sets error bit 1, which stays until cleared.
// RULE14 - writing error bit 2 as 1 clears both sticky fifo flags.
// RULE15 - the loopback path is held in reset while the loopback reset bit is 1; it resets to 0.
// RULE16 - reserved and unmapped bits read zero and ignore writes.
// RULE17 - both sticky flags stay zero while the clear bit is held at 1.
`timescale 1ns/1ps
`default_nettype none

module pcsr_bank
    import pcsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [pcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic familyNewer,
    input wire logic coreLowLatency100,
    input wire logic refClk644,
    input wire logic coreFourLane,
    input wire logic coreTimestamp,
    input wire logic coreLocalFault,
    input wire logic loopbackMode,
    input wire logic [7:0] dieTemperature,
    input wire logic fifoUnderflow,
    input wire logic fifoOverflow,
    output logic generatorStop,
    output logic loopbackPathReset,
    output logic irq
);
    import pcsr_pkg::*;

    logic [31:0] scratchWord;
    logic [3:0] genCtrl;
    logic lbClear;
    logic [1:0] lbSticky;
    logic lbReset;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic [ADDR_W-1:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic [FEAT_W-1:0] featureVector;
    logic [7:0] tempSync1;
    logic [7:0] tempSync2;
    logic [1:0] evSync1;
    logic [1:0] evSync2;
    logic [1:0] evPrev;
    logic [1:0] evRise;
    logic [6:0] strapSync1;
    logic [6:0] strapSync2;
    logic doWrite;
    logic writeHit;
    logic [31:0] readValue;
    logic readHit;

    // word index from a byte address; low two bits ignored
    function automatic logic [15:0] wordIndex(input logic [ADDR_W-1:0] addr);
        wordIndex = addr[ADDR_W-1:2];
    endfunction

    function automatic logic isMapped(input logic [15:0] idx);
        isMapped = (idx == IDX_SCRATCH) || (idx == IDX_IDENT) || (idx == IDX_FEATURE)
            || (idx == IDX_TEMP) || (idx == IDX_GENCTRL) || (idx == IDX_LBERR)
            || (idx == IDX_LBRESET) || (idx == IDX_IRQSTAT) || (idx == IDX_IRQMASK);
    endfunction

    // write channel: address and data are caught independently
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign writeHit = doWrite && isMapped(wordIndex(awAddr));

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? RESP_OKAY : RESP_SLVERR; // RULE16
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // scratch word honours byte strobes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scratchWord <= SCRATCH_RESET;
        end else if (writeHit && wordIndex(awAddr) == IDX_SCRATCH) begin
            for (int b = 0; b < 4; b++) begin
                if (wStrb[b]) begin
                    scratchWord[8*b +: 8] <= wData[8*b +: 8]; // RULE1
                end
            end
        end
    end

    // bit 3 is status only and bits 0 and 2 keep their reset values
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            genCtrl <= GENCTRL_RESET; // RULE10
        end else if (writeHit && wordIndex(awAddr) == IDX_GENCTRL && wStrb[0]) begin
            genCtrl[GEN_DISABLE] <= wData[GEN_DISABLE]; // RULE10
        end
    end
    assign generatorStop = genCtrl[GEN_DISABLE]; // RULE10

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lbReset <= LBRESET_RESET; // RULE15
        end else if (writeHit && wordIndex(awAddr) == IDX_LBRESET && wStrb[0]) begin
            lbReset <= wData[0]; // RULE15
        end
    end
    assign loopbackPathReset = lbReset; // RULE15

    // clear bit is a level held by software until written back to 0
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lbClear <= 1'b0;
        end else if (writeHit && wordIndex(awAddr) == IDX_LBERR && wStrb[0]) begin
            lbClear <= wData[LB_CLEAR]; // RULE14
        end
    end

    // external status passes two flops before use
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tempSync1 <= 8'h00;
            tempSync2 <= 8'h00;
            evSync1 <= 2'h0;
            evSync2 <= 2'h0;
            evPrev <= 2'h0;
            strapSync1 <= 7'h00;
            strapSync2 <= 7'h00;
        end else begin
            tempSync1 <= dieTemperature;
            tempSync2 <= tempSync1;
            evSync1 <= {fifoOverflow, fifoUnderflow};
            evSync2 <= evSync1;
            evPrev <= evSync2;
            strapSync1 <= {loopbackMode, coreLocalFault, coreTimestamp, coreFourLane,
                refClk644, coreLowLatency100, familyNewer};
            strapSync2 <= strapSync1;
        end
    end
    assign evRise = evSync2 & ~evPrev;

    // clear holds flags at zero while asserted; set wins otherwise
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lbSticky <= LBERR_RESET;
        end else if (lbClear) begin
            lbSticky <= 2'h0; // RULE14 RULE17
        end else begin
            lbSticky[LB_UNDER] <= lbSticky[LB_UNDER] | evRise[LB_UNDER]; // RULE12
            lbSticky[LB_OVER] <= lbSticky[LB_OVER] | evRise[LB_OVER]; // RULE13
        end
    end

    // interrupt status: write one to clear, a new event wins over the clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqStatus <= IRQ_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (evRise[i]) begin
                    irqStatus[i] <= 1'b1;
                end else if (writeHit && wordIndex(awAddr) == IDX_IRQSTAT && wStrb[0]
                        && wData[i]) begin
                    irqStatus[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqMask <= IRQ_RESET;
        end else if (writeHit && wordIndex(awAddr) == IDX_IRQMASK && wStrb[0]) begin
            irqMask <= wData[1:0];
        end
    end
    assign irq = |(irqStatus & irqMask);

    always_comb begin
        featureVector = '0;
        featureVector[FEAT_FAMILY] = strapSync2[0]; // RULE3
        featureVector[FEAT_LL100] = strapSync2[1]; // RULE4
        featureVector[FEAT_REFCLK] = strapSync2[2]; // RULE5
        featureVector[FEAT_FOURLANE] = strapSync2[3]; // RULE6
        featureVector[FEAT_TSTAMP] = strapSync2[4]; // RULE6
        featureVector[FEAT_LFAULT] = strapSync2[5]; // RULE6
        featureVector[FEAT_EXTPLL] = 1'b0; // RULE7
        featureVector[FEAT_STDSTREAM] = 1'b1; // RULE8
    end

    always_comb begin
        readValue = 32'h0000_0000;
        readHit = 1'b1;
        unique case (wordIndex(s_axi_araddr))
            IDX_SCRATCH: readValue = scratchWord; // RULE1
            IDX_IDENT: readValue = IDENT_VALUE; // RULE2
            IDX_FEATURE: readValue[FEAT_W-1:0] = featureVector;
            IDX_TEMP: readValue[7:0] = tempSync2; // RULE9
            IDX_GENCTRL: readValue[3:0] = {strapSync2[6], genCtrl[2], genCtrl[GEN_DISABLE],
                genCtrl[0]}; // RULE11
            IDX_LBERR: readValue[2:0] = {lbClear, lbSticky};
            IDX_LBRESET: readValue[0] = lbReset;
            IDX_IRQSTAT: readValue[1:0] = irqStatus;
            IDX_IRQMASK: readValue[1:0] = irqMask;
            default: readHit = 1'b0; // RULE16
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readValue;
            s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- verification/pcsr_bank_properties.sv ----
// bus timing and fixed field checks for the packet client register bank
// assumes a bind to pcsr_bank with one clock core_clk and async low resetn
`timescale 1ns/1ps
`default_nettype none
module pcsr_bank_properties
    import pcsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [pcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [pcsr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic generatorStop,
    input wire logic loopbackPathReset
);
    import pcsr_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic wrBoth;
    logic arTake;
    assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_wstrb[0];
    assign arTake = s_axi_arvalid && s_axi_arready;
    chk_b_latency: assert property (wrBoth |=> ##1 s_axi_bvalid)
        else $error("write response late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_latency: assert property (arTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_ident_read: assert property (arTake && s_axi_araddr == 18'h4004 |=> s_axi_rdata == IDENT_VALUE)
        else $error("identification word wrong");
    chk_unmapped_read: assert property (arTake && s_axi_araddr == 18'h4010 |=>
        s_axi_rdata == 32'h0000_0000 && s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    chk_feature_fixed: assert property (arTake && s_axi_araddr == 18'h4008 |=>
        s_axi_rdata[31:7] == 25'h000_0004 && !s_axi_rdata[3])
        else $error("fixed feature bits wrong");
    chk_stop_write: assert property (wrBoth && s_axi_awaddr == 18'h4040 |->
        ##3 generatorStop == $past(s_axi_wdata[1], 3))
        else $error("generator stop not written");
    chk_lbreset_write: assert property (wrBoth && s_axi_awaddr == 18'h4058 |->
        ##3 loopbackPathReset == $past(s_axi_wdata[0], 3))
        else $error("loopback reset not written");
    cover property (wrBoth && s_axi_awaddr == 18'h4040);
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property (loopbackPathReset);
endmodule
`default_nettype wire

// ---- verification/packet_client_csr_bank_tb.sv ----
// self-checking bench for the packet client register bank
// assumes pcsr_pkg, pcsr_bank and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module packet_client_csr_bank_tb;
    import pcsr_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, irq, generatorStop, loopbackPathReset;
    logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic familyNewer = 1'b0, coreLowLatency100 = 1'b0, refClk644 = 1'b0, coreFourLane = 1'b0;
    logic coreTimestamp = 1'b0, coreLocalFault = 1'b0, loopbackMode = 1'b0;
    logic fifoUnderflow = 1'b0, fifoOverflow = 1'b0;
    logic [7:0] dieTemperature = '0;
    int fails = 0;
    int comparisons = 0;
    pcsr_bank dut_u (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .familyNewer,
        .coreLowLatency100, .refClk644, .coreFourLane, .coreTimestamp, .coreLocalFault,
        .loopbackMode, .dieTemperature, .fifoUnderflow, .fifoOverflow, .generatorStop,
        .loopbackPathReset, .irq);
    task automatic close_out();
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // readys are sampled at the falling edge so the next rising edge is the take edge
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        // let the previous release settle before raising the next request
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge core_clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        fails++;
        close_out();
    endtask
    task automatic rc(input logic [17:0] a, input logic [31:0] exp, input string nm);
        logic ta, tr;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge core_clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            rdv = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                chk(nm, rdv, exp);
                return;
            end
        end
        fails++;
        close_out();
    endtask
    task automatic ev(input bit ov);
        if (ov) fifoOverflow <= 1'b1;
        else fifoUnderflow <= 1'b1;
        repeat (2) @(posedge core_clk);
        fifoOverflow <= 1'b0;
        fifoUnderflow <= 1'b0;
        repeat (5) @(posedge core_clk);
    endtask
    task automatic t_regs();
        rc(18'h4040, 32'h0000_0005, "genctrl reset");
        rc(18'h4058, 32'h0000_0000, "lbreset reset");
        wr(18'h4000, 32'h1234_5678, 4'hF);
        wr(18'h4000, 32'hFFFF_FFFF, 4'h5);
        rc(18'h4000, 32'h12FF_56FF, "scratch");
        wr(18'h4004, 32'h0000_0000, 4'hF);
        rc(18'h4004, IDENT_VALUE, "ident");
        rc(18'h4010, 32'h0000_0000, "unmapped read");
        chk("unmapped read resp", rs, RESP_SLVERR);
        wr(18'h4010, 32'h0000_0001, 4'hF);
        chk("unmapped write resp", rs, RESP_SLVERR);
    endtask
    task automatic t_feature();
        logic [5:0] p;
        for (int i = 0; i < 2; i++) begin
            p = i ? 6'h15 : 6'h2A;
            {familyNewer, coreLowLatency100, refClk644} <= p[5:3];
            {coreFourLane, coreTimestamp, coreLocalFault} <= p[2:0];
            dieTemperature <= {p, 2'b01};
            repeat (4) @(posedge core_clk);
            rc(18'h4008, {22'h00_0000, 3'b100, p[0], p[1], p[2], 1'b0, p[3], p[4], p[5]},
                "feature");
            rc(18'h4018, {24'h00_0000, p, 2'b01}, "temperature");
        end
    endtask
    task automatic t_control();
        loopbackMode <= 1'b1;
        wr(18'h4040, 32'h0000_000A, 4'hF);
        chk("stop set", generatorStop, 32'h0000_0001);
        rc(18'h4040, 32'h0000_000F, "genctrl loopback");
        loopbackMode <= 1'b0;
        wr(18'h4040, 32'h0000_0000, 4'hF);
        chk("stop clear", generatorStop, 32'h0000_0000);
        rc(18'h4040, 32'h0000_0005, "genctrl generator");
        wr(18'h4058, 32'h0000_0001, 4'hF);
        chk("lbreset set", loopbackPathReset, 32'h0000_0001);
        wr(18'h4058, 32'h0000_0000, 4'hF);
        chk("lbreset clear", loopbackPathReset, 32'h0000_0000);
    endtask
    task automatic t_lberr();
        ev(1'b0);
        rc(18'h4054, 32'h0000_0001, "underflow flag");
        ev(1'b1);
        rc(18'h4054, 32'h0000_0003, "overflow flag");
        wr(18'h4054, 32'h0000_0004, 4'hF);
        rc(18'h4054, 32'h0000_0004, "flags cleared");
        ev(1'b0);
        rc(18'h4054, 32'h0000_0004, "flag held clear");
        wr(18'h4054, 32'h0000_0003, 4'hF);
        ev(1'b1);
        rc(18'h4054, 32'h0000_0002, "flag after clear");
        wr(18'h4080, 32'h0000_0003, 4'hF);
        ev(1'b1);
        chk("irq masked", irq, 32'h0000_0000);
        wr(18'h4084, 32'h0000_0002, 4'hF);
        chk("irq raised", irq, 32'h0000_0001);
        wr(18'h4080, 32'h0000_0002, 4'hF);
        chk("irq cleared", irq, 32'h0000_0000);
    endtask
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        chk("stop after reset", generatorStop, 32'h0000_0000);
        t_regs();
        t_feature();
        t_control();
        t_lberr();
        close_out();
    end
endmodule
bind pcsr_bank pcsr_bank_properties chk_u (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .generatorStop, .loopbackPathReset);
`default_nettype wire
